// [src/pmc_pkg.sv]
// Package with register map, field positions, timing counts and types of the power mode controller.
package pmc_pkg;

  // ==========================================================================
  // Register map (byte addresses on APB).
  // ==========================================================================
  localparam logic [11:0] CTRL_ADDR   = 12'h000;
  localparam logic [11:0] STATUS_ADDR = 12'h004;
  localparam logic [11:0] REGEN_ADDR  = 12'h008;

  // ==========================================================================
  // Field positions.
  // ==========================================================================
  localparam int CTRL_MODE_LSB   = 0;   // Requested low power mode, two bits.
  localparam int CTRL_RETA_BIT   = 4;   // Keep retention bank A in coma.
  localparam int CTRL_RETB_BIT   = 5;   // Keep retention bank B in coma.
  localparam int CTRL_FLASH0_BIT = 8;   // Flash bank 0 powered at coma wake-up.
  localparam int CTRL_FLASH1_BIT = 9;   // Flash bank 1 powered at coma wake-up.
  localparam int REGEN_SW_BIT    = 0;   // Switching regulator enable.

  localparam int ST_STATE_LSB    = 0;   // Current mode, three bits.
  localparam int ST_LOWV_BIT     = 4;   // Low-voltage supply mode.
  localparam int ST_DBG_BIT      = 5;   // Debugger attached.
  localparam int ST_REFUSED_BIT  = 6;   // Last coma request refused.
  localparam int ST_STALL_BIT    = 7;   // Processor held stalled.

  // ==========================================================================
  // Reset values.
  // ==========================================================================
  localparam logic [31:0] CTRL_RESET  = 32'h0000_0330;
  localparam logic [31:0] REGEN_RESET = 32'h0000_0000;

  // ==========================================================================
  // Modes requested by software.
  // ==========================================================================
  localparam logic [1:0] REQ_RUN   = 2'h0;
  localparam logic [1:0] REQ_SLEEP = 2'h1;
  localparam logic [1:0] REQ_DEEP  = 2'h2;
  localparam logic [1:0] REQ_COMA  = 2'h3;

  // ==========================================================================
  // Timing budgets in microseconds and derived cycle counts at 125 MHz.
  // ==========================================================================
  localparam int CLK_MHZ        = 125;
  localparam int ENTER_US       = 2;
  localparam int DEEP_WAKE_US   = 200;
  localparam int COMA_WAKE_US   = 400;
  localparam int ENTER_CYCLES   = ENTER_US * CLK_MHZ;
  localparam int DEEP_WAKE_CYC  = DEEP_WAKE_US * CLK_MHZ;
  localparam int COMA_WAKE_CYC  = COMA_WAKE_US * CLK_MHZ;

  // ==========================================================================
  // Types.
  // ==========================================================================
  typedef enum logic [2:0] {
    PMC_RUN,
    PMC_ENTER,
    PMC_SLEEP,
    PMC_DEEP,
    PMC_COMA,
    PMC_WAKE_FLASH,
    PMC_WAKE_COMA
  } pmc_state_e;

  // Power and clock controls sent to the domains.
  typedef struct packed {
    logic       digital_on;
    logic [1:0] flash_on;
    logic [1:0] ret_sram_on;
    logic       osc32m_on;
    logic       cpu_clk_en;
    logic       cpu_on_lowspeed;
    logic       cpu_stall;
    logic       ana_ldo_on;
    logic       dig_ldo_on;
  } pmc_power_s;

  // Supply regulator controls.
  typedef struct packed {
    logic lowv_mode;
    logic prereg_on;
    logic linear_on;
    logic switching_on;
  } pmc_supply_s;

endpackage

// [src/pmc_top.sv]
// Power mode controller sequencing run, sleep, deep sleep and coma.
//
// Design decisions made here: the register offsets and register access over APB.
`timescale 1ns/1ns

//Contract
// - Four software selected modes exist
// - Run powers everything, clock runs (after coma wake, flash banks not set in CTRL[9:8] stay off)
// - Sleep gates processor clock only
// - Interrupt in sleep returns to run
// - Deep sleep also powers flash down
// - Deep wake restores flash then runs
// - Coma keeps retention, programmable SRAM banks
// - Coma stops 32 MHz, low speed clock
// - Coma wake powers flash and digital
// - Stall processor until flash ready
// - Wake flash banks follow software settings (coma wake only; deep wake powers both banks)
// - Refuse coma while debugger attached
// - Both supplies low selects low-voltage mode
// - High-voltage mode starts on linear regulator
// - Regulators follow operating state automatically (LDOs only; prereg, linear and switching follow supply mode and REGEN)
// - Budget enter and wake latencies
module pmc_top #(
  parameter int DEEP_WAKE_CYCLES = pmc_pkg::DEEP_WAKE_CYC,
  parameter int COMA_WAKE_CYCLES = pmc_pkg::COMA_WAKE_CYC
) (
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  input  wire logic [3:0]         pstrb,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic               cpu_wfi,
  input  wire logic               irq_pending,
  input  wire logic [1:0]         flash_ready,
  input  wire logic               debug_port_enable_pin,
  input  wire logic               main_supply_input_low,
  input  wire logic               core_supply_rail_low,
  output pmc_pkg::pmc_power_s     power_q,
  output pmc_pkg::pmc_supply_s    supply_q
);

  // ==========================================================================
  // Register file.
  // ==========================================================================
  logic [31:0]         ctrl_q;
  logic [31:0]         regen_q;
  logic                refused_q;
  pmc_pkg::pmc_state_e state_q;
  logic [31:0]         cnt_q;
  logic                lowv_q;
  logic                coma_req;

  logic                apb_access;
  logic                apb_wr;
  logic                addr_ok;
  logic [31:0]         status_w;
  logic [31:0]         wmask;

  assign apb_access = psel && penable;
  assign apb_wr     = apb_access && pwrite;
  assign addr_ok    = (paddr == pmc_pkg::CTRL_ADDR) || (paddr == pmc_pkg::STATUS_ADDR) ||
                      (paddr == pmc_pkg::REGEN_ADDR);
  assign wmask      = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

  // Status word assembled from live state.
  always_comb begin
    status_w = 32'h0000_0000;
    status_w[pmc_pkg::ST_STATE_LSB +: 3] = state_q;
    status_w[pmc_pkg::ST_LOWV_BIT]       = lowv_q;
    status_w[pmc_pkg::ST_DBG_BIT]        = debug_port_enable_pin;
    status_w[pmc_pkg::ST_REFUSED_BIT]    = refused_q;
    status_w[pmc_pkg::ST_STALL_BIT]      = power_q.cpu_stall;
  end

  // Control register writes with byte strobes; only defined bits are kept.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= pmc_pkg::CTRL_RESET;
    end else if (apb_wr && paddr == pmc_pkg::CTRL_ADDR) begin
      ctrl_q <= ((ctrl_q & ~wmask) | (pwdata & wmask)) & 32'h0000_0333;
    end
  end

  // Switching regulator enable, only meaningful in high-voltage mode.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      regen_q <= pmc_pkg::REGEN_RESET;
    end else if (apb_wr && paddr == pmc_pkg::REGEN_ADDR) begin
      regen_q <= ((regen_q & ~wmask) | (pwdata & wmask)) & 32'h0000_0001;
    end
  end

  // Read data and one-cycle response; unmapped addresses answer with an error.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !pready;
      pslverr <= psel && !pready && !addr_ok;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          pmc_pkg::CTRL_ADDR:   prdata <= ctrl_q;
          pmc_pkg::STATUS_ADDR: prdata <= status_w;
          pmc_pkg::REGEN_ADDR:  prdata <= regen_q;
          default:              prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ==========================================================================
  // Mode sequencer.
  // ==========================================================================
  assign coma_req = ctrl_q[pmc_pkg::CTRL_MODE_LSB +: 2] == pmc_pkg::REQ_COMA;

  // Sequence of modes; entry waits for an idle processor with no interrupt pending.
  // The wait flag still stands for two cycles after wake, so a pending interrupt blocks re-entry.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= pmc_pkg::PMC_RUN;
      cnt_q   <= 32'h0000_0000;
    end else begin
      case (state_q)
        pmc_pkg::PMC_RUN: begin
          if (cpu_wfi && !irq_pending && ctrl_q[1:0] != pmc_pkg::REQ_RUN &&
              !(coma_req && debug_port_enable_pin)) begin
            state_q <= pmc_pkg::PMC_ENTER;
            cnt_q   <= 32'(pmc_pkg::ENTER_CYCLES - 1);
          end
        end
        pmc_pkg::PMC_ENTER: begin
          if (cnt_q == 32'h0000_0000) begin
            case (ctrl_q[1:0])
              pmc_pkg::REQ_SLEEP: state_q <= pmc_pkg::PMC_SLEEP;
              pmc_pkg::REQ_DEEP:  state_q <= pmc_pkg::PMC_DEEP;
              pmc_pkg::REQ_COMA:  state_q <= debug_port_enable_pin ? pmc_pkg::PMC_RUN
                                                                  : pmc_pkg::PMC_COMA;
              default:            state_q <= pmc_pkg::PMC_RUN;
            endcase
          end else begin
            cnt_q <= cnt_q - 32'h0000_0001;
          end
        end
        pmc_pkg::PMC_SLEEP: begin
          if (irq_pending) begin
            state_q <= pmc_pkg::PMC_RUN;
          end
        end
        pmc_pkg::PMC_DEEP: begin
          if (irq_pending) begin
            state_q <= pmc_pkg::PMC_WAKE_FLASH;
            cnt_q   <= 32'(DEEP_WAKE_CYCLES - 1);
          end
        end
        pmc_pkg::PMC_COMA: begin
          if (irq_pending) begin
            state_q <= pmc_pkg::PMC_WAKE_COMA;
            cnt_q   <= 32'(COMA_WAKE_CYCLES - 1);
          end
        end
        pmc_pkg::PMC_WAKE_FLASH,
        pmc_pkg::PMC_WAKE_COMA: begin
          if (cnt_q != 32'h0000_0000) begin
            cnt_q <= cnt_q - 32'h0000_0001;
          end else if ((flash_ready & ctrl_q[9:8]) == ctrl_q[9:8]) begin
            state_q <= pmc_pkg::PMC_RUN;
          end
        end
        default: state_q <= pmc_pkg::PMC_RUN;
      endcase
    end
  end

  // Sticky flag for a coma request turned away by an attached debugger.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      refused_q <= 1'b0;
    end else if (state_q == pmc_pkg::PMC_RUN && cpu_wfi && coma_req &&
                 debug_port_enable_pin) begin
      refused_q <= 1'b1;
    end else if (apb_wr && paddr == pmc_pkg::STATUS_ADDR && pwdata[pmc_pkg::ST_REFUSED_BIT]) begin
      refused_q <= 1'b0;
    end
  end

  // ==========================================================================
  // Power, clock and supply outputs.
  // ==========================================================================
  // Domain controls decoded from the state, all registered.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      power_q <= '{digital_on: 1'b1, flash_on: 2'b11, ret_sram_on: 2'b11, osc32m_on: 1'b1,
                   cpu_clk_en: 1'b1, cpu_on_lowspeed: 1'b0, cpu_stall: 1'b0,
                   ana_ldo_on: 1'b1, dig_ldo_on: 1'b1};
    end else begin
      power_q.digital_on      <= state_q != pmc_pkg::PMC_COMA;
      power_q.ret_sram_on     <= (state_q == pmc_pkg::PMC_COMA) ?
                                 ctrl_q[5:4] : 2'b11;
      power_q.osc32m_on       <= state_q != pmc_pkg::PMC_COMA;
      power_q.cpu_on_lowspeed <= state_q == pmc_pkg::PMC_COMA;
      power_q.cpu_clk_en      <= state_q == pmc_pkg::PMC_RUN || state_q == pmc_pkg::PMC_ENTER;
      power_q.cpu_stall       <= state_q == pmc_pkg::PMC_WAKE_COMA ||
                                 state_q == pmc_pkg::PMC_WAKE_FLASH;
      power_q.ana_ldo_on      <= state_q != pmc_pkg::PMC_COMA;
      power_q.dig_ldo_on      <= state_q != pmc_pkg::PMC_COMA;
      case (state_q)
        pmc_pkg::PMC_DEEP,
        pmc_pkg::PMC_COMA:       power_q.flash_on <= 2'b00;
        pmc_pkg::PMC_WAKE_COMA:  power_q.flash_on <= ctrl_q[9:8];
        pmc_pkg::PMC_RUN:        power_q.flash_on <= power_q.flash_on | ctrl_q[9:8];
        default:                 power_q.flash_on <= power_q.flash_on | 2'b11;
      endcase
    end
  end

  // Supply mode detection; linear regulator is the default in high voltage.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lowv_q   <= 1'b0;
      supply_q <= '{lowv_mode: 1'b0, prereg_on: 1'b1, linear_on: 1'b1, switching_on: 1'b0};
    end else begin
      lowv_q                <= main_supply_input_low && core_supply_rail_low;
      supply_q.lowv_mode    <= lowv_q;
      supply_q.prereg_on    <= !lowv_q;
      supply_q.switching_on <= !lowv_q && regen_q[pmc_pkg::REGEN_SW_BIT];
      supply_q.linear_on    <= !lowv_q && !regen_q[pmc_pkg::REGEN_SW_BIT];
    end
  end

  // ==========================================================================
  // Assertions.
  // ==========================================================================
  sequence s_coma_wake;
    state_q == pmc_pkg::PMC_COMA && irq_pending;
  endsequence

  a_no_coma_dbg: assert property (@(posedge clk) disable iff (!rst_n)
    debug_port_enable_pin && $stable(debug_port_enable_pin) && state_q == pmc_pkg::PMC_ENTER
    |=> state_q != pmc_pkg::PMC_COMA)
    else $error("coma entered with debugger attached");

  a_run_needs_wfi: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == pmc_pkg::PMC_RUN && !cpu_wfi |=> state_q == pmc_pkg::PMC_RUN)
    else $error("left run without processor waiting");

  a_sleep_wake: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == pmc_pkg::PMC_SLEEP && irq_pending |=> state_q == pmc_pkg::PMC_RUN
    ##1 power_q.cpu_clk_en)
    else $error("sleep did not wake to run");

  a_coma_wake: assert property (@(posedge clk) disable iff (!rst_n)
    s_coma_wake |=> state_q == pmc_pkg::PMC_WAKE_COMA ##1 power_q.digital_on)
    else $error("coma wake did not power digital");

  a_stall_flash: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == pmc_pkg::PMC_WAKE_COMA && (flash_ready & ctrl_q[9:8]) != ctrl_q[9:8]
    |=> state_q != pmc_pkg::PMC_RUN)
    else $error("run resumed before flash ready");

  a_coma_clocks: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == pmc_pkg::PMC_COMA && $past(state_q) == pmc_pkg::PMC_COMA
    |-> !power_q.osc32m_on && power_q.cpu_on_lowspeed && !power_q.cpu_clk_en)
    else $error("coma clocks wrong");

  a_deep_flash: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == pmc_pkg::PMC_DEEP && $past(state_q) == pmc_pkg::PMC_DEEP
    |-> power_q.flash_on == 2'b00 && power_q.digital_on && power_q.osc32m_on)
    else $error("deep sleep power wrong");

  a_lowv_prereg: assert property (@(posedge clk) disable iff (!rst_n)
    main_supply_input_low && core_supply_rail_low ##1 lowv_q |=> !supply_q.prereg_on)
    else $error("prereg on in low-voltage mode");

endmodule

// [verif/pmc_cpu_model.sv]
// Behavioural processor core, interrupt source and flash banks facing the controller.
`timescale 1ns/1ns
module pmc_cpu_model (
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire pmc_pkg::pmc_power_s power_q,
  input  wire logic                wfi_req,
  input  wire logic                irq_req,
  input  wire logic [7:0]          flash_delay,
  output logic                     cpu_wfi,
  output logic                     irq_pending,
  output logic [1:0]               flash_ready
);
  logic [7:0] fcnt_q [2];
  logic       running;

  // The core only makes progress with its clock on and no stall.
  assign running = power_q.cpu_clk_en & ~power_q.cpu_stall;

  // Software parks the core in wait-for-interrupt; a serviced interrupt lets it go on.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_wfi     <= 1'b0;
      irq_pending <= 1'b0;
    end else if (wfi_req) begin
      cpu_wfi <= 1'b1;
    end else if (irq_req) begin
      irq_pending <= 1'b1;
    end else if (running && irq_pending) begin
      cpu_wfi     <= 1'b0;
      irq_pending <= 1'b0;
    end
  end

  // Each flash bank reports ready some cycles after power arrives, and drops at once.
  always_ff @(posedge clk or negedge rst_n) begin
    for (int b = 0; b < 2; b++) begin
      if (!rst_n || !power_q.flash_on[b]) begin
        fcnt_q[b]      <= 8'h00;
        flash_ready[b] <= 1'b0;
      end else if (fcnt_q[b] < flash_delay) begin
        fcnt_q[b] <= fcnt_q[b] + 8'h01;
      end else begin
        flash_ready[b] <= 1'b1;
      end
    end
  end
endmodule

// [verif/pmc_top_test.sv]
// Self-checking bench for the power mode controller.
`timescale 1ns/1ns
module pmc_top_test;
  logic                clk = 1'b0;
  logic                rst_n = 1'b0;
  logic                psel = 1'b0;
  logic                penable = 1'b0;
  logic                pwrite = 1'b0;
  logic [11:0]         paddr = 12'h000;
  logic [31:0]         pwdata = '0;
  logic [31:0]         prdata, rd, c;
  logic                pready, pslverr, er, saw_stall;
  logic                cpu_wfi, irq_pending;
  logic [1:0]          flash_ready, m, fl;
  logic                wfi_req = 1'b0;
  logic                irq_req = 1'b0;
  logic                dbg = 1'b0;
  logic                mlow = 1'b0;
  logic                clow = 1'b0;
  logic [7:0]          flash_delay = 8'h05;
  pmc_pkg::pmc_power_s  power_q;
  pmc_pkg::pmc_supply_s supply_q;
  int                  err_count = 0;
  int                  compares = 0;
  int                  waited, seed, bits;

  // Free-running 125 MHz clock.
  always #4 clk = ~clk;

  pmc_top #(.DEEP_WAKE_CYCLES(20), .COMA_WAKE_CYCLES(40)) u_pmc_top (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cpu_wfi(cpu_wfi), .irq_pending(irq_pending),
    .flash_ready(flash_ready), .debug_port_enable_pin(dbg), .main_supply_input_low(mlow),
    .core_supply_rail_low(clow), .power_q(power_q), .supply_q(supply_q));

  pmc_cpu_model u_pmc_cpu_model (
    .clk(clk), .rst_n(rst_n), .power_q(power_q), .wfi_req(wfi_req), .irq_req(irq_req),
    .flash_delay(flash_delay), .cpu_wfi(cpu_wfi), .irq_pending(irq_pending),
    .flash_ready(flash_ready));

  // Compares one value and counts it.
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic conclude();
    $display("mismatches %0d comparisons %0d", err_count, compares);
    if (err_count == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Counts a hung wait as a mismatch and ends the run.
  task automatic hang(input string what);
    err_count++;
    $display("[ERR] %s expected done seen timeout", what);
    conclude();
  endtask

  // One APB transfer, entered just after a rising edge; read data lands in rd, the error response in er.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      hang("apb");
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  // Waits for the processor clock enable to reach v, noting any stall on the way.
  task automatic wait_en(input logic v);
    waited = 0;
    saw_stall = 1'b0;
    while (power_q.cpu_clk_en !== v) begin
      @(posedge clk);
      waited++;
      saw_stall |= power_q.cpu_stall;
      if (waited > 5000) begin
        hang("clock enable");
      end
    end
  endtask

  // Expected digital, flash, retention, oscillator and low speed controls in a low state.
  function automatic logic [6:0] exp_pwr(input logic [1:0] md, input logic [1:0] rt);
    if (md == pmc_pkg::REQ_SLEEP) return 7'h7e;
    if (md == pmc_pkg::REQ_DEEP) return 7'h4e;
    return {3'b000, rt, 2'b01};
  endfunction

  // Main sequence: reset, register checks, mode loop, debugger and supply cases.
  initial begin
    seed = 32'hfd3c_bfd8;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk("supply", 32'(supply_q), 32'h0000_0006);
    chk("run", 32'({power_q.digital_on, power_q.flash_on, power_q.ret_sram_on,
        power_q.osc32m_on, power_q.cpu_clk_en, power_q.ana_ldo_on}), 32'h0000_00ff);
    apb(1'b0, pmc_pkg::CTRL_ADDR, '0);
    chk("ctrl", rd, pmc_pkg::CTRL_RESET);
    apb(1'b0, 12'h0fc, '0);
    chk("unmapped", 32'(er), 32'h0000_0001);
    apb(1'b1, pmc_pkg::CTRL_ADDR, pmc_pkg::CTRL_RESET | 32'h0000_0001);
    repeat (300) @(posedge clk);
    chk("no wfi", 32'(power_q.cpu_clk_en), 32'h0000_0001);
    for (int i = 0; i < 6; i++) begin
      m = 2'(1 + i % 3);
      bits = $random(seed);
      fl = 2'(1 + {bits[7:0]} % 3);
      c = {22'h0, fl, 2'b00, bits[5:4], 2'b00, m};
      flash_delay <= 8'(bits[12:8]);
      apb(1'b1, pmc_pkg::CTRL_ADDR, c);
      wfi_req <= 1'b1;
      @(posedge clk);
      wfi_req <= 1'b0;
      wait_en(1'b0);
      chk("enter", 32'(waited >= pmc_pkg::ENTER_CYCLES && waited < 260), 32'h0000_0001);
      apb(1'b0, pmc_pkg::STATUS_ADDR, '0);
      chk("state", 32'(rd[2:0]), 32'(m) + 32'h0000_0001);
      chk("low", 32'({power_q.digital_on, power_q.flash_on, power_q.ret_sram_on,
          power_q.osc32m_on, power_q.cpu_on_lowspeed}), 32'(exp_pwr(m, bits[5:4])));
      chk("ldo", 32'({power_q.ana_ldo_on, power_q.dig_ldo_on}),
          (m == 2'd3) ? 32'h0000_0000 : 32'h0000_0003);
      irq_req <= 1'b1;
      @(posedge clk);
      irq_req <= 1'b0;
      wait_en(1'b1);
      chk("wake flash", 32'(power_q.flash_on), 32'((m == 2'd3) ? fl : 2'b11));
      chk("flash ready", 32'(flash_ready & power_q.flash_on), 32'(power_q.flash_on));
      chk("wake on", 32'({power_q.digital_on, power_q.osc32m_on, power_q.cpu_stall}), 32'h6);
      if (m == 2'd1) chk("sleep wake", 32'(waited < 5), 32'h0000_0001);
      if (m == 2'd3) chk("stall", 32'(saw_stall), 32'h0000_0001);
      apb(1'b1, pmc_pkg::CTRL_ADDR, c & 32'hffff_fffc);
    end
    dbg <= 1'b1;
    apb(1'b1, pmc_pkg::CTRL_ADDR, pmc_pkg::CTRL_RESET | 32'h0000_0003);
    wfi_req <= 1'b1;
    @(posedge clk);
    wfi_req <= 1'b0;
    repeat (300) @(posedge clk);
    chk("debug run", 32'(power_q.cpu_clk_en), 32'h0000_0001);
    apb(1'b0, pmc_pkg::STATUS_ADDR, '0);
    chk("refused", 32'(rd[pmc_pkg::ST_REFUSED_BIT]), 32'h0000_0001);
    apb(1'b1, pmc_pkg::CTRL_ADDR, pmc_pkg::CTRL_RESET);
    irq_req <= 1'b1;
    @(posedge clk);
    irq_req <= 1'b0;
    dbg <= 1'b0;
    // A debugger that arrives during entry sends the coma request back to run.
    apb(1'b1, pmc_pkg::CTRL_ADDR, pmc_pkg::CTRL_RESET | 32'h0000_0003);
    wfi_req <= 1'b1;
    @(posedge clk);
    wfi_req <= 1'b0;
    repeat (100) @(posedge clk);
    dbg <= 1'b1;
    repeat (300) @(posedge clk);
    apb(1'b0, pmc_pkg::STATUS_ADDR, '0);
    chk("late debug", 32'(rd[2:0]), 32'h0000_0000);
    chk("late debug run", 32'(power_q.cpu_clk_en), 32'h0000_0001);
    apb(1'b1, pmc_pkg::CTRL_ADDR, pmc_pkg::CTRL_RESET);
    irq_req <= 1'b1;
    @(posedge clk);
    irq_req <= 1'b0;
    dbg <= 1'b0;
    // The refused flag clears when one is written to it.
    apb(1'b1, pmc_pkg::STATUS_ADDR, 32'h0000_0001 << pmc_pkg::ST_REFUSED_BIT);
    apb(1'b0, pmc_pkg::STATUS_ADDR, '0);
    chk("refused clear", 32'(rd[pmc_pkg::ST_REFUSED_BIT]), 32'h0000_0000);
    apb(1'b1, pmc_pkg::REGEN_ADDR, 32'h0000_0001);
    repeat (4) @(posedge clk);
    chk("switching", 32'(supply_q.switching_on), 32'h0000_0001);
    chk("linear", 32'(supply_q.linear_on), 32'h0000_0000);
    mlow <= 1'b1;
    clow <= 1'b1;
    repeat (6) @(posedge clk);
    chk("low supply", 32'({supply_q.lowv_mode, supply_q.prereg_on}), 32'h0000_0002);
    conclude();
  end
endmodule
